// [inc/gameport_pkg.sv]
// Purpose: shared constants and types of the two-device game port
// Assumes: 100 MHz core clock, 8-bit register port with 4-bit offsets
// Notes: axis order is device A X, device A Y, device B X, device B Y
package gameport_pkg;
   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_AXES = 4;
   localparam int NUM_BTNS = 4;
   localparam int CNT_W = 16;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_LEGACY = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_XSTAT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_COUNT_FIRST = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LAST = 4'hb;

   // control register layout
   localparam int CTRL_ENH_BIT = 0;
   localparam int CTRL_PRE_A_BIT = 1;
   localparam int CTRL_PRE_B_BIT = 2;
   localparam int CTRL_DEB_LSB = 4;
   localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'hf7;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

   // legacy status layout
   localparam int LEG_AXIS_LSB = 0;
   localparam int LEG_BTN_LSB = 4;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int DISCHARGE_NS = 1500;
   localparam int DISCHARGE_CYC = DISCHARGE_NS / CLK_PERIOD_NS;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_DIV_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DEBOUNCE_MS = 16;
   localparam int DEBOUNCE_TICKS_DEF = DEBOUNCE_MS * 1000000 / TICK_PERIOD_NS;
   localparam int DEB_CNT_W = 16;

   localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;

   // per-axis sequence, gray coded along idle, charge, discharge
   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_CHARGE = 2'b01,
      AX_DISCHARGE = 2'b11
   } axis_state_t;
endpackage

// [inc/axis_link_if.sv]
// Purpose: carrier between the port core and one axis channel
// Assumes: one instance per axis line
// Notes: level is the sampled pin, drive is the pin output enable
`timescale 1ns/1ps
interface axis_link_if;
   import gameport_pkg::*;
   logic start;
   logic tick;
   logic enhanced;
   logic level;
   logic drive;
   logic released;
   logic ready_pulse;
   logic [CNT_W-1:0] count;
   modport ctl (output start, output tick, output enhanced, output level,
                input drive, input released, input ready_pulse, input count);
   modport chan (input start, input tick, input enhanced, input level,
                 output drive, output released, output ready_pulse, output count);
endinterface

// [core/axis_channel.sv]
// Purpose: one axis line: release, charge timing, discharge and hold low
// Assumes: level is already sampled to clk; tick is a one-cycle enable
// Notes: counter saturates at full scale and stays there until restarted
`timescale 1ns/1ps
module axis_channel (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link to the port core
   axis_link_if.chan link
);
   import gameport_pkg::*;

   axis_state_t state;
   axis_state_t next_state;
   logic [7:0] dis_cnt;
   logic accept;
   logic at_full;

   assign accept = link.start && (state == AX_IDLE);
   assign at_full = (link.count == CNT_FULL);

   // next state of the axis sequence
   always_comb begin
      next_state = state;
      case (state)
         AX_IDLE: begin
            if (accept) begin
               next_state = AX_CHARGE;
            end
         end
         AX_CHARGE: begin
            if (link.level) begin
               next_state = AX_DISCHARGE;
            end
         end
         AX_DISCHARGE: begin
            if (dis_cnt == 8'(DISCHARGE_CYC - 1)) begin
               next_state = AX_IDLE;
            end
         end
         default: begin
            next_state = AX_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= AX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // pin drive: low in every state but charge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.drive <= 1'b1;
      end else begin
         link.drive <= (next_state != AX_CHARGE);
      end
   end

   // discharge interval timer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dis_cnt <= 8'h00;
      end else if (state == AX_DISCHARGE) begin
         dis_cnt <= dis_cnt + 8'h01;
      end else begin
         dis_cnt <= 8'h00;
      end
   end

   // position counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.count <= '0;
      end else if (accept && link.enhanced) begin
         link.count <= '0;
      end else if (link.enhanced && state == AX_CHARGE && !link.level && link.tick && !at_full) begin
         link.count <= link.count + 16'h0001;
      end
   end

   // ready pulse when counting stops: line high or full scale reached
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.ready_pulse <= 1'b0;
      end else begin
         link.ready_pulse <= link.enhanced && (state == AX_CHARGE) &&
            (link.level || (link.tick && link.count == CNT_FULL - 16'h0001));
      end
   end

   assign link.released = (state == AX_CHARGE);
endmodule // axis_channel

// [core/game_port.sv]
// Purpose: two-device game port with legacy polling and enhanced timing
// Assumes: register port of address, write/read strobes, data one cycle later
// Notes: axis pins are open drain; out is always low, oe high while driving
`timescale 1ns/1ps
module game_port #(
   parameter int DEBOUNCE_TICKS = gameport_pkg::DEBOUNCE_TICKS_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [gameport_pkg::ADDR_W-1:0] addr,
   input wire logic [gameport_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [gameport_pkg::DATA_W-1:0] rd_data,
   // axis pins, index 0 device A, index 1 device B
   input wire logic [1:0] horizontal_axis_line_in,
   output logic [1:0] horizontal_axis_line_out,
   output logic [1:0] horizontal_axis_line_oe,
   input wire logic [1:0] vertical_axis_line_in,
   output logic [1:0] vertical_axis_line_out,
   output logic [1:0] vertical_axis_line_oe,
   // buttons: A0, A1, B0, B1
   input wire logic [gameport_pkg::NUM_BTNS-1:0] button_input_lines
);
   import gameport_pkg::*;

   // true when an offset addresses one of the count bytes
   function automatic logic is_count(input logic [ADDR_W-1:0] a);
      is_count = (a >= OFS_COUNT_FIRST) && (a <= OFS_COUNT_LAST);
   endfunction

   // axis index of a count byte offset
   function automatic logic [1:0] count_axis(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel = a - OFS_COUNT_FIRST;
      count_axis = rel[2:1];
   endfunction

   logic [DATA_W-1:0] port_control_reg;
   logic [NUM_AXES-1:0] ready;
   logic [NUM_AXES-1:0] axis_level;
   logic [NUM_BTNS-1:0] btn_sample;
   logic [NUM_BTNS-1:0] btn_clean;
   logic [NUM_BTNS-1:0] btn_shown;
   logic [NUM_AXES-1:0] released;
   logic [NUM_AXES-1:0] released_q;
   logic [NUM_AXES-1:0] drive;
   logic [NUM_AXES-1:0] ready_pulse;
   logic [CNT_W-1:0] count [NUM_AXES];
   logic [7:0] high_hold [NUM_AXES];
   logic [6:0] div_cnt;
   logic tick_fast;
   logic tick_half;
   logic tick_slow;
   logic enhanced;
   logic start_wr;
   logic [DATA_W-1:0] button_axis_level_status;
   logic [DATA_W-1:0] extended_event_status_reg;
   logic [DATA_W-1:0] next_rd_data;

   assign enhanced = port_control_reg[CTRL_ENH_BIT];
   assign start_wr = wr_en && (addr == OFS_LEGACY);

   // control register; reserved bit 3 stays zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_control_reg <= CTRL_RESET;
      end else if (wr_en && addr == OFS_CTRL) begin
         port_control_reg <= wr_data & CTRL_WR_MASK;
      end
   end

   // input sampling of axis and button pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         axis_level <= '0;
         btn_sample <= '0;
      end else begin
         axis_level <= {vertical_axis_line_in[1], horizontal_axis_line_in[1],
                        vertical_axis_line_in[0], horizontal_axis_line_in[0]};
         btn_sample <= button_input_lines;
      end
   end

   // 1 MHz tick from the core clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 7'h00;
         tick_fast <= 1'b0;
      end else if (div_cnt == 7'(TICK_DIV_CYC - 1)) begin
         div_cnt <= 7'h00;
         tick_fast <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         tick_fast <= 1'b0;
      end
   end

   // 500 kHz tick: every second fast tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_half <= 1'b0;
      end else if (tick_fast) begin
         tick_half <= ~tick_half;
      end
   end
   assign tick_slow = tick_fast && tick_half;

   // axis channels, device A on 0 and 1, device B on 2 and 3
   axis_link_if link [NUM_AXES] ();
   generate
      for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
         localparam int PRE_BIT = (i < 2) ? CTRL_PRE_A_BIT : CTRL_PRE_B_BIT;
         assign link[i].start = start_wr;
         assign link[i].tick = port_control_reg[PRE_BIT] ? tick_slow : tick_fast;
         assign link[i].enhanced = enhanced;
         assign link[i].level = axis_level[i];
         assign drive[i] = link[i].drive;
         assign released[i] = link[i].released;
         assign ready_pulse[i] = link[i].ready_pulse;
         assign count[i] = link[i].count;
         axis_channel u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .link(link[i])
         );
      end
   endgenerate

   // open-drain pins: output level always low, enable from channel flop
   assign horizontal_axis_line_out = 2'b00;
   assign vertical_axis_line_out = 2'b00;
   assign horizontal_axis_line_oe = {drive[2], drive[0]};
   assign vertical_axis_line_oe = {drive[3], drive[1]};

   // button debouncers, counted in 1 MHz ticks
   generate
      for (genvar b = 0; b < NUM_BTNS; b++) begin : g_btn
         logic [DEB_CNT_W-1:0] stable_cnt;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stable_cnt <= '0;
               btn_clean[b] <= 1'b0;
            end else if (btn_sample[b] == btn_clean[b]) begin
               stable_cnt <= '0;
            end else if (tick_fast) begin
               if (stable_cnt == DEB_CNT_W'(DEBOUNCE_TICKS - 1)) begin
                  btn_clean[b] <= btn_sample[b];
                  stable_cnt <= '0;
               end else begin
                  stable_cnt <= stable_cnt + 1'b1;
               end
            end
         end
         // raw level unless enhanced with debounce enabled
         assign btn_shown[b] = (enhanced && port_control_reg[CTRL_DEB_LSB + b]) ?
                               btn_clean[b] : btn_sample[b];
      end
   endgenerate

   // previous released state; its rise marks a start that the axis really took
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         released_q <= '0;
      end else begin
         released_q <= released;
      end
   end

   // ready flags: hardware set wins over a write-one clear
   // a start refused by a discharging axis must not wipe that axis's finished result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready <= '0;
      end else begin
         for (int i = 0; i < NUM_AXES; i++) begin
            if (ready_pulse[i]) begin
               ready[i] <= 1'b1;
            end else if (wr_en && addr == OFS_XSTAT && wr_data[i]) begin
               ready[i] <= 1'b0;
            end else if (enhanced && released[i] && !released_q[i]) begin
               ready[i] <= 1'b0; // accepted start, one cycle late
            end
         end
      end
   end

   // high byte captured when its low byte is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_AXES; i++) begin
            high_hold[i] <= 8'h00;
         end
      end else if (rd_en && is_count(addr) && !addr[0]) begin
         high_hold[count_axis(addr)] <= count[count_axis(addr)][15:8];
      end
   end

   assign button_axis_level_status = {btn_shown, released};
   assign extended_event_status_reg = {4'h0, ready};

   // read data mux
   always_comb begin
      next_rd_data = 8'h00;
      if (rd_en) begin
         if (addr == OFS_CTRL) begin
            next_rd_data = port_control_reg;
         end else if (addr == OFS_LEGACY) begin
            next_rd_data = button_axis_level_status;
         end else if (addr == OFS_XSTAT) begin
            next_rd_data = extended_event_status_reg;
         end else if (is_count(addr)) begin
            if (addr[0]) begin
               next_rd_data = high_hold[count_axis(addr)];
            end else begin
               next_rd_data = count[count_axis(addr)][7:0];
            end
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule // game_port

// [verif/gp_properties.sv]
// Purpose: port-level checks of the game port
// Assumes: one clock, async active-low reset
// Notes: axis order AX AY BX BY
`timescale 1ns/1ps
module gp_properties #(
   parameter int DEBOUNCE_TICKS = gameport_pkg::DEBOUNCE_TICKS_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [gameport_pkg::ADDR_W-1:0] addr,
   input wire logic [gameport_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [gameport_pkg::DATA_W-1:0] rd_data,
   // axis pins and buttons
   input wire logic [1:0] horizontal_axis_line_in,
   input wire logic [1:0] horizontal_axis_line_out,
   input wire logic [1:0] horizontal_axis_line_oe,
   input wire logic [1:0] vertical_axis_line_in,
   input wire logic [1:0] vertical_axis_line_out,
   input wire logic [1:0] vertical_axis_line_oe,
   input wire logic [gameport_pkg::NUM_BTNS-1:0] button_input_lines
);
   import gameport_pkg::*;
   logic [3:0] oe4, in4, in4_q, idl, dm, chg;
   logic [7:0] hc [4];
   logic [DATA_W-1:0] ctrl_m;
   // pins gathered in register order
   assign oe4 = {vertical_axis_line_oe[1], horizontal_axis_line_oe[1], vertical_axis_line_oe[0], horizontal_axis_line_oe[0]};
   assign in4 = {vertical_axis_line_in[1], horizontal_axis_line_in[1], vertical_axis_line_in[0], horizontal_axis_line_in[0]};
   // cycles each line has been held low, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            hc[i] <= 8'hff;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!oe4[i]) begin
               hc[i] <= 8'h00;
            end else if (hc[i] != 8'hff) begin
               hc[i] <= hc[i] + 8'h01;
            end
         end
      end
   end
   // control mirror and delayed pin levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_m <= CTRL_RESET;
         in4_q <= 4'h0;
      end else begin
         in4_q <= in4;
         if (wr_en && addr == OFS_CTRL) ctrl_m <= wr_data & CTRL_WR_MASK;
      end
   end
   // idle and discharging lines
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         idl[i] = hc[i] > 8'h9b;
         dm[i] = oe4[i] && hc[i] < 8'h94;
      end
   end
   assign chg = ~oe4 & ~in4 & ~in4_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence start_wr;
      wr_en && addr == OFS_LEGACY;
   endsequence
   sequence raw_rd;
      rd_en && addr == OFS_LEGACY && (!ctrl_m[CTRL_ENH_BIT] || ctrl_m[7:4] == 4'h0);
   endsequence
   idle_hold_a: assert property (!(wr_en && addr == OFS_LEGACY) |=> (oe4 & $past(oe4)) == $past(oe4))
      else $error("axis released without start");
   start_release_a: assert property (start_wr ##0 idl == 4'hf |=> oe4 == 4'h0)
      else $error("idle axes not released");
   discharge_hold_a: assert property (dm != 4'h0 |=> (oe4 & $past(dm)) == $past(dm))
      else $error("discharge cut short");
   charge_hold_a: assert property (chg != 4'h0 |=> (~oe4 & $past(chg)) == $past(chg))
      else $error("charging line driven early");
   sense_ax_a: assert property (!oe4[0] && in4[0] |-> ##[1:2] oe4[0])
      else $error("axis AX not discharged");
   sense_by_a: assert property (!oe4[3] && in4[3] |-> ##[1:2] oe4[3])
      else $error("axis BY not discharged");
   status_view_a: assert property (
      raw_rd ##0 (button_input_lines == $past(button_input_lines))
         ##0 (button_input_lines == $past(button_input_lines, 2))
      |=> rd_data == {$past(button_input_lines), ~$past(oe4)})
      else $error("legacy status mismatch");
   ctrl_readback_a: assert property (rd_en && addr == OFS_CTRL |=> rd_data == $past(ctrl_m))
      else $error("control readback mismatch");
endmodule // gp_properties
bind game_port gp_properties #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .horizontal_axis_line_in(horizontal_axis_line_in), .horizontal_axis_line_out(horizontal_axis_line_out),
   .horizontal_axis_line_oe(horizontal_axis_line_oe), .vertical_axis_line_in(vertical_axis_line_in),
   .vertical_axis_line_out(vertical_axis_line_out), .vertical_axis_line_oe(vertical_axis_line_oe),
   .button_input_lines(button_input_lines));

// [verif/rc_model.sv]
// Purpose: R-C axis networks of two game devices
// Assumes: the port pulls a line low while its hold bit is high
// Notes: a released line rises after its charge time
`timescale 1ns/1ps
module rc_model (
   // clock
   input wire logic clk,
   // port drive, high while the line is pulled low
   input wire logic [3:0] hold_low,
   // charge time per axis in clock cycles
   input wire logic [3:0][15:0] rc_cyc,
   // resolved line levels
   output logic [3:0] level
);
   logic [3:0][15:0] t;
   // charge timers restart whenever the port pulls low
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         t[i] <= hold_low[i] ? 16'h0000 : t[i] + {15'h0000, t[i] != 16'hffff};
      end
   end
   // open-drain wire: low while held, pulled high once charged
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level[i] = !hold_low[i] && t[i] >= rc_cyc[i];
      end
   end
endmodule // rc_model

// [verif/game_port_test.sv]
// Purpose: self-checking bench of the game port
// Assumes: debounce shortened to 4 ticks
// Notes: reads are checked from a queue of expected ranges
`timescale 1ns/1ps
module game_port_test;
   import gameport_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic rd_d = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic [1:0] hx_oe, vy_oe, hx_out, vy_out;
   logic [3:0] oe4, lvl, b;
   logic [3:0] btn = 4'h0;
   logic [3:0][15:0] rc = 64'h0;
   logic [7:0] lo_q[$], hi_q[$];
   logic [7:0] e_lo [8] = '{8'h08, 8'h00, 8'h02, 8'h01, 8'h08, 8'h00, 8'h13, 8'h00};
   logic [7:0] e_hi [8] = '{8'h0c, 8'h00, 8'h06, 8'h01, 8'h0c, 8'h00, 8'h17, 8'h00};
   int num_errors = 0;
   int n_compared = 0;
   int seed = 78;
   assign oe4 = {vy_oe[1], hx_oe[1], vy_oe[0], hx_oe[0]};
   // clock
   initial begin
      forever #5 clk = ~clk;
   end
   game_port #(.DEBOUNCE_TICKS(4)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .horizontal_axis_line_in({lvl[2], lvl[0]}),
      .horizontal_axis_line_out(hx_out), .horizontal_axis_line_oe(hx_oe), .vertical_axis_line_in({lvl[3], lvl[1]}),
      .vertical_axis_line_out(vy_out), .vertical_axis_line_oe(vy_oe), .button_input_lines(btn));
   rc_model u_rc (.clk(clk), .hold_low(oe4), .rc_cyc(rc), .level(lvl));
   // register bus cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      lo_q.push_back(lo);
      hi_q.push_back(hi);
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
   task automatic chk_oe(input logic [3:0] exp);
      #1;
      n_compared++;
      if (oe4 !== exp) begin
         num_errors++;
         $display("unexpected axis_oe expected %h seen %h", exp, oe4);
      end
      // open-drain level must stay low whatever the enable does
      n_compared++;
      if ({vy_out, hx_out} !== 4'h0) begin
         num_errors++;
         $display("unexpected axis_out expected 0 seen %h", {vy_out, hx_out});
      end
   endtask
   task automatic check_byte();
      logic [7:0] lo, hi;
      lo = lo_q.pop_front();
      hi = hi_q.pop_front();
      n_compared++;
      if ((rd_data >= lo) !== 1'b1 || (rd_data <= hi) !== 1'b1) begin
         num_errors++;
         $display("unexpected rd_data expected %h..%h seen %h", lo, hi, rd_data);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // read data stands one cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) check_byte();
      rd_d <= rd_en;
   end
   // hang guard
   initial begin
      repeat (50000) @(posedge clk);
      num_errors++;
      final_report();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      chk_oe(4'hf);
      rd(OFS_CTRL, 8'h00, 8'h00);
      rd(4'h3, 8'h00, 8'h00);
      $display("reset test done");
      wr(OFS_CTRL, 8'hf0);
      rd(OFS_CTRL, 8'hf0, 8'hf0);
      rc <= {16'h012c, 16'h04b0, 16'h0320, 16'h01f4};
      b = 4'($random(seed));
      btn <= b;
      wr(OFS_LEGACY, 8'h00);
      chk_oe(4'h0);
      rd(OFS_LEGACY, {b, 4'hf}, {b, 4'hf});
      repeat (600) @(posedge clk);
      b = 4'($random(seed));
      btn <= b;
      rd(OFS_LEGACY, {b, 4'h6}, {b, 4'h6});
      wr(OFS_LEGACY, 8'h00);
      chk_oe(4'h1);
      rd(OFS_LEGACY, {b, 4'he}, {b, 4'he});
      repeat (1000) @(posedge clk);
      chk_oe(4'hf);
      rd(OFS_LEGACY, {b, 4'h0}, {b, 4'h0});
      $display("legacy test done");
      wr(OFS_CTRL, 8'hff);
      rd(OFS_CTRL, 8'hf7, 8'hf7);
      wr(OFS_CTRL, 8'h05);
      rc <= {16'h1068, 16'h0834, 16'h6590, 16'h041a};
      wr(OFS_LEGACY, 8'h00);
      repeat (26300) @(posedge clk);
      rd(OFS_XSTAT, 8'h0f, 8'h0f);
      for (int k = 0; k < 8; k++) rd(OFS_COUNT_FIRST + 4'(k), e_lo[k], e_hi[k]);
      wr(OFS_XSTAT, 8'h0f);
      rd(OFS_XSTAT, 8'h00, 8'h00);
      wr(4'hc, 8'($random(seed)));
      rd(4'hc, 8'h00, 8'h00);
      $display("enhanced test done");
      wr(OFS_CTRL, 8'h11);
      btn <= 4'h0;
      repeat (1000) @(posedge clk);
      btn <= 4'h3;
      repeat (200) @(posedge clk);
      btn <= 4'h2;
      repeat (300) @(posedge clk);
      rd(OFS_LEGACY, 8'h20, 8'h20);
      btn <= 4'h3;
      repeat (250) @(posedge clk);
      rd(OFS_LEGACY, 8'h20, 8'h20);
      repeat (350) @(posedge clk);
      rd(OFS_LEGACY, 8'h30, 8'h30);
      repeat (2) @(posedge clk);
      $display("debounce test done");
      final_report();
   end
endmodule // game_port_test
